// *** rsfl_defines.vh ***
// constants for the rail sequencing and fault latch block
`ifndef RSFL_DEFINES_VH
`define RSFL_DEFINES_VH

// timing
`define RSFL_CLK_PERIOD_NS 8
`define RSFL_SAMPLE_DELAY_NS 50
`define RSFL_SAMPLE_CYCLES \
    ((`RSFL_SAMPLE_DELAY_NS + `RSFL_CLK_PERIOD_NS - 1) / `RSFL_CLK_PERIOD_NS)
`define RSFL_UV_DELAY_NS 2000
`define RSFL_UV_CYCLES (`RSFL_UV_DELAY_NS / `RSFL_CLK_PERIOD_NS)
`define RSFL_OC_SKIP_CYCLES 8

// register byte offsets
`define RSFL_ADDR_STATE 8'h00
`define RSFL_ADDR_IRQ_STATUS 8'h04
`define RSFL_ADDR_IRQ_MASK 8'h08
`define RSFL_ADDR_CTRL 8'h0C

// irq status / mask bit positions
`define RSFL_IRQ_OC_5V 0
`define RSFL_IRQ_OC_3V3 1
`define RSFL_IRQ_UV 2
`define RSFL_IRQ_OV_5V 3
`define RSFL_IRQ_OV_3V3 4
`define RSFL_IRQ_W 5

// reset values
`define RSFL_CTRL_RESET 2'h3
`define RSFL_MASK_RESET 5'h00

// axi responses
`define RSFL_RESP_OKAY 2'h0
`define RSFL_RESP_SLVERR 2'h2

`endif

// *** rsfl_rail_sequencer.v ***
// rail sequencing, current limit, fault latch logic with an axi4-lite register slave
`include "rsfl_defines.vh"
`default_nettype none

module rsfl_rail_sequencer (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control pins
    input wire master_shutdown_n,
    input wire rail_5v_enable_n,
    input wire rail_3v3_enable_n,
    // switching oscillator and per-rail analog comparators, bit 0 = 5v, bit 1 = 3v3
    input wire osc_tick,
    input wire [1:0] pwm_request,
    input wire [1:0] overcurrent_sense,
    input wire [1:0] undervoltage_sense,
    input wire [1:0] overvoltage_sense,
    // gate drives and rail enables
    output reg [1:0] upper_gate_drive,
    output reg [1:0] lower_gate_drive,
    output reg standby_5v_enable,
    output reg standby_3v3_enable,
    output reg boost_enable,
    output reg low_power_mode,
    output reg irq,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // constants and states

    localparam integer SAMPLE_INT = `RSFL_SAMPLE_CYCLES;
    localparam integer SKIP_INT = `RSFL_OC_SKIP_CYCLES;
    localparam integer UV_INT = `RSFL_UV_CYCLES;
    localparam [3:0] SAMPLE_CNT = SAMPLE_INT[3:0];
    localparam [3:0] SKIP_CNT = SKIP_INT[3:0];
    localparam [8:0] UV_CNT = UV_INT[8:0];

    localparam [2:0] ST_SHUTDOWN = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_UV_LATCH = 3'h4;

    // register select: 0 state, 1 irq status, 2 irq mask, 3 ctrl, 4 unmapped
    function [2:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `RSFL_ADDR_STATE: reg_sel = 3'h0;
                `RSFL_ADDR_IRQ_STATUS: reg_sel = 3'h1;
                `RSFL_ADDR_IRQ_MASK: reg_sel = 3'h2;
                `RSFL_ADDR_CTRL: reg_sel = 3'h3;
                default: reg_sel = 3'h4;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    reg [2:0] state;
    reg [2:0] next_state;
    reg [8:0] uv_cnt;
    reg [3:0] samp_cnt [0:1];
    reg [3:0] skip_cnt [0:1];
    reg [1:0] held_over;
    reg [1:0] oc_latch;
    reg [1:0] ov_prev;
    reg [1:0] ctrl_enable;
    reg [4:0] irq_status;
    reg [4:0] irq_mask;
    reg [4:0] events;
    reg [1:0] rail_on;
    reg [1:0] next_upper;
    reg [1:0] next_lower;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg wr_fire;
    reg aw_done;
    reg w_done;
    reg [4:0] w1c;
    wire [1:0] rail_pin;
    integer i;
    integer j;
    integer k;

    assign rail_pin = {rail_3v3_enable_n, rail_5v_enable_n};

    ////////////////////////////////////////////////////////////////////////////////
    // mode state machine

    always @* begin
        case (state)
            ST_SHUTDOWN: begin
                next_state = master_shutdown_n ? ST_RUN : ST_SHUTDOWN;
            end
            ST_RUN: begin
                if (!master_shutdown_n) begin
                    next_state = ST_SHUTDOWN;
                end else if (uv_cnt == UV_CNT) begin
                    next_state = ST_UV_LATCH;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_UV_LATCH: begin
                // only a master shutdown pulse or power cycle clears the latch
                next_state = master_shutdown_n ? ST_UV_LATCH : ST_SHUTDOWN;
            end
            default: begin
                next_state = ST_SHUTDOWN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gate drive decisions

    always @* begin
        for (i = 0; i < 2; i = i + 1) begin
            rail_on[i] = (state == ST_RUN) && master_shutdown_n && rail_pin[i]
                && ctrl_enable[i] && !oc_latch[i];
            // skipping suppresses the high-side pulse, holding current at the limit
            next_upper[i] = rail_on[i] && pwm_request[i] && !held_over[i]
                && !overvoltage_sense[i] && (next_state == ST_RUN);
            // crowbar has no latch, so it follows the comparator cycle by cycle
            next_lower[i] = !next_upper[i]
                && ((rail_on[i] && !pwm_request[i] && (next_state == ST_RUN))
                || (overvoltage_sense[i] && (state != ST_SHUTDOWN)
                && master_shutdown_n));
        end
    end

    always @* begin
        events = 5'h00;
        for (j = 0; j < 2; j = j + 1) begin
            events[`RSFL_IRQ_OC_5V + j] = rail_on[j] && held_over[j] && osc_tick
                && (skip_cnt[j] == SKIP_CNT - 4'h1);
            events[`RSFL_IRQ_OV_5V + j] = overvoltage_sense[j] && !ov_prev[j];
        end
        events[`RSFL_IRQ_UV] = (state == ST_RUN) && (next_state == ST_UV_LATCH);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault tracking and outputs

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_SHUTDOWN;
            uv_cnt <= 9'h000;
            held_over <= 2'h0;
            oc_latch <= 2'h0;
            ov_prev <= 2'h0;
            upper_gate_drive <= 2'h0;
            lower_gate_drive <= 2'h0;
            standby_5v_enable <= 1'b0;
            standby_3v3_enable <= 1'b0;
            boost_enable <= 1'b0;
            low_power_mode <= 1'b1;
            for (k = 0; k < 2; k = k + 1) begin
                samp_cnt[k] <= 4'h0;
                skip_cnt[k] <= 4'h0;
            end
        end else begin
            state <= next_state;
            ov_prev <= overvoltage_sense;
            // qualify only while a main rail is driven and the level stays low
            if ((state == ST_RUN) && (|rail_on) && (|undervoltage_sense)) begin
                if (uv_cnt != UV_CNT) begin
                    uv_cnt <= uv_cnt + 9'h001;
                end
            end else begin
                uv_cnt <= 9'h000;
            end
            for (k = 0; k < 2; k = k + 1) begin
                if (!lower_gate_drive[k]) begin
                    samp_cnt[k] <= 4'h0;
                end else if (samp_cnt[k] != SAMPLE_CNT) begin
                    samp_cnt[k] <= samp_cnt[k] + 4'h1;
                end
                if (!rail_on[k]) begin
                    held_over[k] <= 1'b0;
                end else if (lower_gate_drive[k] && (samp_cnt[k] == SAMPLE_CNT - 4'h1)) begin
                    held_over[k] <= overcurrent_sense[k];
                end
                if (!rail_on[k] || !held_over[k]) begin
                    skip_cnt[k] <= 4'h0;
                end else if (osc_tick) begin
                    skip_cnt[k] <= skip_cnt[k] + 4'h1;
                end
                if (!master_shutdown_n) begin
                    oc_latch[k] <= 1'b0;
                end else if (events[`RSFL_IRQ_OC_5V + k]) begin
                    oc_latch[k] <= 1'b1;
                end
            end
            upper_gate_drive <= next_upper;
            lower_gate_drive <= next_lower;
            standby_5v_enable <= master_shutdown_n;
            standby_3v3_enable <= master_shutdown_n;
            boost_enable <= rail_on[0] && (next_state == ST_RUN);
            low_power_mode <= !master_shutdown_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and control

    always @* begin
        w1c = 5'h00;
        if (wr_fire && w_strb[0] && (reg_sel(aw_addr) == 3'h1)) begin
            w1c = w_data[4:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 5'h00;
            irq_mask <= `RSFL_MASK_RESET;
            ctrl_enable <= `RSFL_CTRL_RESET;
            irq <= 1'b0;
        end else begin
            // a new event in the clearing cycle stays set
            irq_status <= (irq_status & ~w1c) | events;
            if (wr_fire && w_strb[0] && (reg_sel(aw_addr) == 3'h2)) begin
                irq_mask <= w_data[4:0];
            end
            if (wr_fire && w_strb[0] && (reg_sel(aw_addr) == 3'h3)) begin
                ctrl_enable <= w_data[1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    always @* begin
        // only a write whose two halves are both in may fire, never idle readies after reset
        wr_fire = aw_done && w_done && !s_axi_bvalid;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSFL_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RSFL_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            aw_done <= 1'b0;
            w_done <= 1'b0;
        end else begin
            // readies rise one cycle after reset, and again after each response
            if (s_axi_bvalid) begin
                if (s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready <= 1'b1;
                end
            end else if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_sel(aw_addr) == 3'h4) ? `RSFL_RESP_SLVERR
                    : `RSFL_RESP_OKAY;
                aw_done <= 1'b0;
                w_done <= 1'b0;
            end else begin
                if (s_axi_awready && s_axi_awvalid) begin
                    s_axi_awready <= 1'b0;
                    aw_done <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end else if (!s_axi_awready && !aw_done) begin
                    s_axi_awready <= 1'b1;
                end
                if (s_axi_wready && s_axi_wvalid) begin
                    s_axi_wready <= 1'b0;
                    w_done <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end else if (!s_axi_wready && !w_done) begin
                    s_axi_wready <= 1'b1;
                end
            end
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                    s_axi_arready <= 1'b1;
                end
            end else if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RSFL_RESP_OKAY;
                case (reg_sel(s_axi_araddr))
                    3'h0: s_axi_rdata <= {20'h0_0000, state, oc_latch, held_over,
                        lower_gate_drive, upper_gate_drive, 1'b0};
                    3'h1: s_axi_rdata <= {27'h000_0000, irq_status};
                    3'h2: s_axi_rdata <= {27'h000_0000, irq_mask};
                    3'h3: s_axi_rdata <= {30'h0000_0000, ctrl_enable};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RSFL_RESP_SLVERR;
                    end
                endcase
            end else if (!s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // rsfl_rail_sequencer

`default_nettype wire

// *** rsfl_rail_monitor.sv ***
// assertions on the rail sequencer outputs
`default_nettype none
module rsfl_rail_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control pins
    input wire logic master_shutdown_n,
    input wire logic rail_5v_enable_n,
    input wire logic rail_3v3_enable_n,
    // comparators
    input wire logic [1:0] pwm_request,
    input wire logic [1:0] undervoltage_sense,
    input wire logic [1:0] overvoltage_sense,
    // drives and rails
    input wire logic [1:0] upper_gate_drive,
    input wire logic [1:0] lower_gate_drive,
    input wire logic standby_5v_enable,
    input wire logic standby_3v3_enable,
    input wire logic boost_enable,
    input wire logic low_power_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] uv_cnt;
    logic uv_seen;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // 256 leaves slack over the 250 cycle qualification
    always @(posedge aclk) begin
        if (!aresetn || !master_shutdown_n || undervoltage_sense == 2'h0
            || !(rail_5v_enable_n || rail_3v3_enable_n)) begin
            uv_cnt <= 9'h000;
        end else if (uv_cnt != 9'h1ff) begin
            uv_cnt <= uv_cnt + 9'h001;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn || !master_shutdown_n) begin
            uv_seen <= 1'b0;
        end else if (uv_cnt >= 9'h100) begin
            uv_seen <= 1'b1;
        end
    end
    a_no_overlap: assert property ((upper_gate_drive & lower_gate_drive) == 2'h0)
        else $error("upper and lower drive together");
    a_shutdown_off: assert property (!master_shutdown_n |=>
        upper_gate_drive == 2'h0 && !standby_5v_enable && !standby_3v3_enable
        && !boost_enable && low_power_mode) else $error("output on in shutdown");
    a_standby_on: assert property (master_shutdown_n |=>
        standby_5v_enable && standby_3v3_enable && !low_power_mode)
        else $error("standby rail off");
    a_main_gate: assert property (upper_gate_drive != 2'h0 |->
        $past(master_shutdown_n) &&
        (upper_gate_drive & ~$past({rail_3v3_enable_n, rail_5v_enable_n})) == 2'h0)
        else $error("upper drive on a disabled rail");
    a_upper_cause: assert property (
        (upper_gate_drive & ~$past(pwm_request & ~overvoltage_sense)) == 2'h0)
        else $error("upper drive without request or under overvoltage");
    a_ov_crowbar: assert property (
        master_shutdown_n [*3] ##0 overvoltage_sense != 2'h0 |=>
        (lower_gate_drive & $past(overvoltage_sense)) == $past(overvoltage_sense))
        else $error("crowbar not applied");
    a_uv_latch: assert property (uv_cnt >= 9'h100 |->
        upper_gate_drive == 2'h0 && !boost_enable) else $error("mains on after undervoltage");
    a_uv_hold: assert property (uv_seen && master_shutdown_n |=>
        upper_gate_drive == 2'h0 && standby_5v_enable) else $error("undervoltage latch lost");
endmodule // rsfl_rail_monitor
bind rsfl_rail_sequencer rsfl_rail_monitor rsfl_rail_monitor_i (.*);
`default_nettype wire

// *** rsfl_mcu_model.sv ***
// system microcontroller model that holds the master shutdown pin
`default_nettype none
module rsfl_mcu_model (
    // clock
    input wire logic aclk,
    // push button and software release
    input wire logic button,
    input wire logic release_req,
    // standby supply
    input wire logic standby_5v_enable,
    // master shutdown pin
    output logic master_shutdown_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hold = 1'b0;
    // latches the pin once standby is up while the button is in contact, until a release request
    always @(posedge aclk) begin
        hold <= !release_req && (hold || (button && standby_5v_enable));
    end
    assign master_shutdown_n = button || hold;
endmodule // rsfl_mcu_model
`default_nettype wire

// *** rail_sequencing_fault_latch_test.sv ***
// self-checking bench for the rail sequencer
`default_nettype none
module rail_sequencing_fault_latch_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, rail_5v_enable_n = 1'b0, rail_3v3_enable_n = 1'b0;
    logic osc_tick = 1'b0, button = 1'b0, release_req = 1'b0;
    logic [1:0] pwm_request = 2'h0, overcurrent_sense = 2'h0;
    logic [1:0] undervoltage_sense = 2'h0, overvoltage_sense = 2'h0;
    logic master_shutdown_n, standby_5v_enable, standby_3v3_enable, boost_enable;
    logic low_power_mode, irq;
    logic [1:0] upper_gate_drive, lower_gate_drive, s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int errors = 0;
    int checks = 0;
    wire [3:0] pw = {low_power_mode, standby_5v_enable, standby_3v3_enable, boost_enable};
    wire [3:0] dr = {upper_gate_drive, lower_gate_drive};
    rsfl_rail_sequencer rsfl_rail_sequencer_i (.*);
    rsfl_mcu_model rsfl_mcu_model_i (.aclk(aclk), .button(button), .release_req(release_req),
        .standby_5v_enable(standby_5v_enable), .master_shutdown_n(master_shutdown_n));
    always #4 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, d);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    // with drop set the microcontroller drops the pin first, then the button brings it back
    task toggle(input logic drop);
        if (drop) begin
            release_req <= 1'b1;
            cyc(1);
            release_req <= 1'b0;
            cyc(3);
        end
        button <= 1'b1;
        cyc(3);
        button <= 1'b0;
        cyc(3);
    endtask
    task finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        aresetn <= 1'b1;
        cyc(3);
        chk("power", 32'(pw), 32'h8);
        rchk(8'h0C, 32'h0000_0003, 2'h0);
        rchk(8'h08, 32'h0000_0000, 2'h0);
        rchk(8'h10, 32'h0000_0000, 2'h2);
        axw(8'h10, 32'h0000_0001);
        chk("bresp", 32'(rs), 32'h2);
        $display("test shutdown done");
        pwm_request <= 2'h3;
        toggle(1'b0);
        chk("power", 32'(pw), 32'h6);
        chk("drives", 32'(dr), 32'h0);
        for (int i = 0; i < 4; i++) begin
            {rail_3v3_enable_n, rail_5v_enable_n} <= i[1:0];
            pwm_request <= 2'h3;
            cyc(3);
            chk("upper", 32'(upper_gate_drive), 32'(i[1:0]));
            chk("boost", 32'(boost_enable), 32'(i[0]));
            pwm_request <= 2'h0;
            cyc(3);
            chk("lower", 32'(lower_gate_drive), 32'(i[1:0]));
        end
        axw(8'h0C, 32'h0000_0001);
        pwm_request <= 2'h3;
        cyc(3);
        chk("upper", 32'(upper_gate_drive), 32'h1);
        rchk(8'h0C, 32'h0000_0001, 2'h0);
        axw(8'h0C, 32'h0000_0003);
        $display("test enables done");
        axw(8'h08, 32'h0000_0008);
        pwm_request <= 2'h3;
        overvoltage_sense <= 2'h2;
        cyc(3);
        chk("irq", 32'(irq), 32'h0);
        overvoltage_sense <= 2'h1;
        cyc(3);
        chk("drives", 32'(dr), 32'h9);
        chk("irq", 32'(irq), 32'h1);
        overvoltage_sense <= 2'h0;
        cyc(3);
        chk("drives", 32'(dr), 32'hc);
        rchk(8'h04, 32'h0000_0018, 2'h0);
        axw(8'h04, 32'h0000_0018);
        cyc(2);
        chk("irq", 32'(irq), 32'h0);
        rchk(8'h04, 32'h0000_0000, 2'h0);
        $display("test overvoltage done");
        overcurrent_sense <= 2'h1;
        // a short low-side period must not yet be sampled
        pwm_request <= 2'h2;
        cyc(4);
        pwm_request <= 2'h3;
        cyc(3);
        chk("upper", 32'(upper_gate_drive), 32'h3);
        pwm_request <= 2'h2;
        cyc(9);
        pwm_request <= 2'h3;
        cyc(3);
        chk("upper", 32'(upper_gate_drive), 32'h2);
        repeat (10) begin
            pwm_request <= 2'h2;
            cyc(9);
            pwm_request <= 2'h3;
            osc_tick <= 1'b1;
            cyc(1);
            osc_tick <= 1'b0;
            cyc(1);
        end
        overcurrent_sense <= 2'h0;
        pwm_request <= 2'h2;
        cyc(3);
        chk("drives", 32'(dr), 32'h8);
        rchk(8'h04, 32'h0000_0001, 2'h0);
        toggle(1'b1);
        chk("drives", 32'(dr), 32'h9);
        $display("test overcurrent done");
        undervoltage_sense <= 2'h1;
        cyc(100);
        chk("drives", 32'(dr), 32'h9);
        cyc(200);
        chk("drives", 32'(dr), 32'h0);
        chk("power", 32'(pw), 32'h6);
        undervoltage_sense <= 2'h0;
        cyc(20);
        chk("drives", 32'(dr), 32'h0);
        toggle(1'b1);
        chk("drives", 32'(dr), 32'h9);
        $display("test undervoltage done");
        finish_test();
    end
    // the tests need about 600 cycles
    initial begin
        #100us;
        errors++;
        finish_test();
    end
endmodule // rail_sequencing_fault_latch_test
`default_nettype wire
